//--- include/jses_pkg.sv
// constants, state types and scan patterns shared by both ends of the self-erase link
`default_nettype none
package jses_pkg;
	// system clock and link timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TCK_HALF_NS   = 50;
	localparam int unsigned TCK_HALF_CYC  =
		(TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HALF_W        = 3;
	localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(TCK_HALF_CYC - 1);

	// waits: cell discharge after the enable load, erase burn in idle
	localparam int unsigned DISCH_US      = 1;
	localparam int unsigned DISCH_CYC     =
		(DISCH_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned ERASE_MS      = 100;
	localparam int unsigned ERASE_CYC     =
		(ERASE_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W       = 24;
	localparam logic [TIMER_W-1:0] DISCH_LAST = TIMER_W'(DISCH_CYC - 1);

	// instruction register
	localparam int unsigned IR_W          = 8;
	localparam logic [IR_W-1:0] LIVE_REPROGRAM_ENABLE_INSTR = 8'hE4;
	localparam logic [IR_W-1:0] ERASE_INSTR   = 8'hED;
	localparam logic [IR_W-1:0] IR_CAPTURE    = 8'h01;
	localparam logic [IR_W-1:0] IR_BYPASS     = 8'hFF;

	// one scan pattern: step count, tms and tdi per step, lsb first
	localparam int unsigned LEN_W         = 4;
	typedef struct packed {
		logic [LEN_W-1:0] len;
		logic [7:0]       tms;
		logic [7:0]       tdi;
	} jses_pat_t;

	localparam jses_pat_t PAT_TLR   = '{len: 4'h5, tms: 8'h1F, tdi: 8'h00};
	localparam jses_pat_t PAT_GO1   = '{len: 4'h5, tms: 8'h06, tdi: 8'h00};
	localparam jses_pat_t PAT_SHEN  = '{len: 4'h8, tms: 8'h80,
		tdi: LIVE_REPROGRAM_ENABLE_INSTR};
	localparam jses_pat_t PAT_UPD1  = '{len: 4'h1, tms: 8'h01, tdi: 8'h00};
	localparam jses_pat_t PAT_GO2   = '{len: 4'h4, tms: 8'h03, tdi: 8'h00};
	localparam jses_pat_t PAT_SHER  = '{len: 4'h8, tms: 8'h80,
		tdi: ERASE_INSTR};
	localparam jses_pat_t PAT_UPD2  = '{len: 4'h2, tms: 8'h01, tdi: 8'h00};
	localparam jses_pat_t PAT_HOLD  = '{len: 4'h1, tms: 8'h00, tdi: 8'h00};

	// sequencer states, gray coded along the scan path
	typedef enum logic [3:0] {
		SQ_IDLE  = 4'h0,
		SQ_TLR   = 4'h1,
		SQ_GO1   = 4'h3,
		SQ_SHEN  = 4'h2,
		SQ_UPD1  = 4'h6,
		SQ_DISCH = 4'h7,
		SQ_GO2   = 4'h5,
		SQ_SHER  = 4'h4,
		SQ_UPD2  = 4'hC,
		SQ_DWELL = 4'hD,
		SQ_GO3   = 4'hF,
		SQ_DONE  = 4'hE
	} jses_seq_state_t;

	// test access port controller states
	typedef enum logic [3:0] {
		TAP_TLR  = 4'h0,
		TAP_RTI  = 4'h1,
		TAP_SDR  = 4'h3,
		TAP_CDR  = 4'h2,
		TAP_SHDR = 4'h6,
		TAP_E1DR = 4'h7,
		TAP_PDR  = 4'h5,
		TAP_E2DR = 4'h4,
		TAP_UDR  = 4'hC,
		TAP_SIR  = 4'hD,
		TAP_CIR  = 4'hF,
		TAP_SHIR = 4'hE,
		TAP_E1IR = 4'hA,
		TAP_PIR  = 4'hB,
		TAP_E2IR = 4'h9,
		TAP_UIR  = 4'h8
	} jses_tap_state_t;
endpackage
`default_nettype wire

//--- include/jses_jtag_if.sv
// scan link between the erase sequencer and the device test port
`default_nettype none
interface jses_jtag_if;
	logic tck;
	logic tms;
	logic tdi;

	modport host
	(
		output tck,
		output tms,
		output tdi
	);

	modport dev
	(
		input tck,
		input tms,
		input tdi
	);
endinterface
`default_nettype wire

//--- hdl/jses_sync.sv
// two-stage level synchroniser into the system clock domain
`default_nettype none
module jses_sync
#(
	parameter int unsigned W = 1
)
(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

//--- hdl/jses_tap_device.sv
// device end: test port controller with live reprogram enable and erase
`default_nettype none
module jses_tap_device
(
	input  wire logic  clk,
	input  wire logic  rstn,
	jses_jtag_if.dev   jtag,
	output var  logic  liveReprogram,
	output var  logic  eraseActive
);
	typedef struct packed {
		jses_pkg::jses_tap_state_t  tap;
		logic [jses_pkg::IR_W-1:0]  shift;
		logic [jses_pkg::IR_W-1:0]  ir;
		logic                       liveEn;
		logic                       erasing;
	} jses_dev_t;

	jses_dev_t s_q;
	jses_dev_t s_d;

	always_comb
	begin
		s_d = s_q;
		case (s_q.tap)
			jses_pkg::TAP_TLR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_TLR : jses_pkg::TAP_RTI;
			jses_pkg::TAP_RTI:
				s_d.tap = jtag.tms ? jses_pkg::TAP_SDR : jses_pkg::TAP_RTI;
			jses_pkg::TAP_SDR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_SIR : jses_pkg::TAP_CDR;
			jses_pkg::TAP_CDR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_E1DR : jses_pkg::TAP_SHDR;
			jses_pkg::TAP_SHDR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_E1DR : jses_pkg::TAP_SHDR;
			jses_pkg::TAP_E1DR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_UDR : jses_pkg::TAP_PDR;
			jses_pkg::TAP_PDR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_E2DR : jses_pkg::TAP_PDR;
			jses_pkg::TAP_E2DR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_UDR : jses_pkg::TAP_SHDR;
			jses_pkg::TAP_UDR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_SDR : jses_pkg::TAP_RTI;
			jses_pkg::TAP_SIR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_TLR : jses_pkg::TAP_CIR;
			jses_pkg::TAP_CIR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_E1IR : jses_pkg::TAP_SHIR;
			jses_pkg::TAP_SHIR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_E1IR : jses_pkg::TAP_SHIR;
			jses_pkg::TAP_E1IR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_UIR : jses_pkg::TAP_PIR;
			jses_pkg::TAP_PIR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_E2IR : jses_pkg::TAP_PIR;
			jses_pkg::TAP_E2IR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_UIR : jses_pkg::TAP_SHIR;
			jses_pkg::TAP_UIR:
				s_d.tap = jtag.tms ? jses_pkg::TAP_SDR : jses_pkg::TAP_RTI;
			default:
				s_d.tap = jses_pkg::TAP_TLR;
		endcase

		// actions belong to the state being left on this edge
		case (s_q.tap)
			jses_pkg::TAP_TLR:
				s_d.ir = jses_pkg::IR_BYPASS;
			jses_pkg::TAP_CIR:
				s_d.shift = jses_pkg::IR_CAPTURE;
			jses_pkg::TAP_SHIR:
				s_d.shift = {jtag.tdi, s_q.shift[jses_pkg::IR_W-1:1]};
			default:
				s_d.shift = s_q.shift;
		endcase

		// load on entry to update-ir
		if (s_d.tap == jses_pkg::TAP_UIR)
		begin
			s_d.ir = s_q.shift;
			if (s_q.shift == jses_pkg::LIVE_REPROGRAM_ENABLE_INSTR)
				s_d.liveEn = 1'b1;
		end

		// erase only runs while live reprogramming is armed, so the user
		// logic keeps working on the old pattern during the burn
		s_d.erasing = (s_d.tap == jses_pkg::TAP_RTI)
			&& (s_d.ir == jses_pkg::ERASE_INSTR)
			&& s_d.liveEn;
	end

	// link clock domain: tck from the other end, stopped outside a scan
	always_ff @(posedge jtag.tck or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '{tap: jses_pkg::TAP_TLR, shift: '0,
				ir: jses_pkg::IR_BYPASS, liveEn: 1'b0, erasing: 1'b0};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	jses_sync
	#(
		.W (2)
	)
	u_sync
	(
		.clk  (clk),
		.rstn (rstn),
		.d    ({s_q.liveEn, s_q.erasing}),
		.q    ({liveReprogram, eraseActive})
	);
endmodule
`default_nettype wire

//--- hdl/jses_sequencer.sv
// erase sequencer: drives the device test port through the self-erase scan
// Overview of operation
// - device reprograms while running once enabled
// - enable instruction goes before any erase instruction
// - set tdi and tms, then raise tck
// - one linear state machine walks all steps
// - timer gives discharge wait and erase burn
// - start tms high, five tck rises
// - tms 0,1,1,0,0 then 1,1,0,0 reach shift-ir
// - shift enable bits 0010011, bit7 1 exits
// - shift erase bits 1011011, bit7 1 exits
// - device sets enable flop at update-ir
// - erase loaded at update-ir, left tms low
// - idle with tms low clocking for 100ms
// - after erase tms 1,1,0,0 to shift-ir
`default_nettype none
module jses_sequencer
#(
	parameter int unsigned ERASE_CYC = jses_pkg::ERASE_CYC
)
(
	input  wire logic  clk,
	input  wire logic  rstn,
	input  wire logic  start,
	jses_jtag_if.host  jtag,
	output var  logic  busy,
	output var  logic  done
);
	typedef struct packed {
		jses_pkg::jses_seq_state_t        state;
		logic [2:0]                       idx;
		logic [jses_pkg::HALF_W-1:0]      half;
		logic [jses_pkg::TIMER_W-1:0]     timer;
		logic                             tck;
		logic                             tms;
		logic                             tdi;
		logic                             busy;
		logic                             done;
	} jses_seq_t;

	localparam logic [jses_pkg::TIMER_W-1:0] ERASE_LAST =
		jses_pkg::TIMER_W'(ERASE_CYC - 1);

	jses_seq_t s_q;
	jses_seq_t s_d;

	// scan pattern that belongs to each state
	function automatic jses_pkg::jses_pat_t seqPat
	(
		input jses_pkg::jses_seq_state_t st
	);
		case (st)
			jses_pkg::SQ_TLR:  seqPat = jses_pkg::PAT_TLR;
			jses_pkg::SQ_GO1:  seqPat = jses_pkg::PAT_GO1;
			jses_pkg::SQ_SHEN: seqPat = jses_pkg::PAT_SHEN;
			jses_pkg::SQ_UPD1: seqPat = jses_pkg::PAT_UPD1;
			jses_pkg::SQ_GO2:  seqPat = jses_pkg::PAT_GO2;
			jses_pkg::SQ_SHER: seqPat = jses_pkg::PAT_SHER;
			jses_pkg::SQ_UPD2: seqPat = jses_pkg::PAT_UPD2;
			jses_pkg::SQ_GO3:  seqPat = jses_pkg::PAT_GO2;
			default:           seqPat = jses_pkg::PAT_HOLD;
		endcase
	endfunction

	// fixed successor: the machine never branches
	function automatic jses_pkg::jses_seq_state_t seqNext
	(
		input jses_pkg::jses_seq_state_t st
	);
		case (st)
			jses_pkg::SQ_TLR:   seqNext = jses_pkg::SQ_GO1;
			jses_pkg::SQ_GO1:   seqNext = jses_pkg::SQ_SHEN;
			jses_pkg::SQ_SHEN:  seqNext = jses_pkg::SQ_UPD1;
			jses_pkg::SQ_UPD1:  seqNext = jses_pkg::SQ_DISCH;
			jses_pkg::SQ_DISCH: seqNext = jses_pkg::SQ_GO2;
			jses_pkg::SQ_GO2:   seqNext = jses_pkg::SQ_SHER;
			jses_pkg::SQ_SHER:  seqNext = jses_pkg::SQ_UPD2;
			jses_pkg::SQ_UPD2:  seqNext = jses_pkg::SQ_DWELL;
			jses_pkg::SQ_DWELL: seqNext = jses_pkg::SQ_GO3;
			jses_pkg::SQ_GO3:   seqNext = jses_pkg::SQ_DONE;
			default:            seqNext = jses_pkg::SQ_IDLE;
		endcase
	endfunction

	always_comb
	begin
		jses_pkg::jses_pat_t pat;
		jses_pkg::jses_pat_t nextPat;
		logic                lastStep;
		logic                advance;
		pat      = seqPat(s_q.state);
		nextPat  = jses_pkg::PAT_HOLD;
		lastStep = ({1'b0, s_q.idx}
			== jses_pkg::LEN_W'(pat.len - jses_pkg::LEN_W'(1)));
		advance  = 1'b0;
		s_d      = s_q;
		s_d.done = 1'b0;

		case (s_q.state)
			jses_pkg::SQ_IDLE:
			begin
				s_d.tck = 1'b0;
				s_d.tms = 1'b1;
				s_d.tdi = 1'b0;
				if (start)
				begin
					s_d.state = jses_pkg::SQ_TLR;
					s_d.idx   = '0;
					s_d.half  = '0;
					s_d.busy  = 1'b1;
				end
			end

			jses_pkg::SQ_DONE:
			begin
				s_d.busy  = 1'b0;
				s_d.done  = 1'b1;
				s_d.state = jses_pkg::SQ_IDLE;
			end

			// tck stays low while the enable flop settles in update-ir
			jses_pkg::SQ_DISCH:
			begin
				if (s_q.timer == jses_pkg::DISCH_LAST)
				begin
					advance = 1'b1;
				end
				else
				begin
					s_d.timer = jses_pkg::TIMER_W'(s_q.timer + 1'b1);
				end
			end

			default:
			begin
				// burn timer runs on clk, tck keeps toggling meanwhile
				if (s_q.state == jses_pkg::SQ_DWELL && s_q.timer != ERASE_LAST)
					s_d.timer = jses_pkg::TIMER_W'(s_q.timer + 1'b1);
				if (s_q.half != jses_pkg::HALF_LAST)
				begin
					s_d.half = jses_pkg::HALF_W'(s_q.half + 1'b1);
				end
				else
				begin
					s_d.half = '0;
					if (!s_q.tck)
					begin
						s_d.tck = 1'b1;
					end
					else
					begin
						s_d.tck = 1'b0;
						if (s_q.state == jses_pkg::SQ_DWELL)
							advance = (s_q.timer == ERASE_LAST);
						else if (lastStep)
							advance = 1'b1;
						else
							s_d.idx = 3'(s_q.idx + 1'b1);
					end
				end
			end
		endcase

		if (advance)
		begin
			s_d.state = seqNext(s_q.state);
			s_d.idx   = '0;
			s_d.timer = '0;
		end

		// new pins are only set with tck low, a full half period before
		// the next rise, so the device sees them settled
		if (s_q.state != jses_pkg::SQ_IDLE && s_d.state != s_q.state
			|| s_d.idx != s_q.idx)
		begin
			nextPat = seqPat(s_d.state);
			s_d.tms = nextPat.tms[s_d.idx];
			s_d.tdi = nextPat.tdi[s_d.idx];
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '{state: jses_pkg::SQ_IDLE, idx: '0, half: '0,
				timer: '0, tck: 1'b0, tms: 1'b1, tdi: 1'b0,
				busy: 1'b0, done: 1'b0};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign jtag.tck = s_q.tck;
	assign jtag.tms = s_q.tms;
	assign jtag.tdi = s_q.tdi;
	assign busy     = s_q.busy;
	assign done     = s_q.done;
endmodule
`default_nettype wire

//--- testbench/jses_monitor.sv
// concurrent checks on the scan link between sequencer and device
`default_nettype none
module jses_monitor
#(
	parameter int unsigned ERASE_CYC = 50
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic done,
	input wire logic liveReprogram,
	input wire logic eraseActive
);
	timeunit 1ns;
	timeprecision 1ps;
	// tms per rise, index 0 at the first rise of a scan
	localparam logic [32:0] TMS_EXP = 33'h0C01E00DF;
	localparam logic [7:0]  EN_OP   = 8'hE4;
	localparam logic [7:0]  ER_OP   = 8'hED;
	logic [7:0] riseCnt_q;
	logic [3:0] lastTms_q;
	logic       tck_q;
	wire logic  rise = tck && !tck_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			riseCnt_q <= 8'h00;
			lastTms_q <= 4'h0;
			tck_q     <= 1'b0;
		end
		else
		begin
			tck_q <= tck;
			if (done)
				riseCnt_q <= 8'h00;
			else if (rise && riseCnt_q != 8'hFF)
				riseCnt_q <= riseCnt_q + 8'h01;
			if (rise)
				lastTms_q <= {lastTms_q[2:0], tms};
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_reset_walk:
	assert property (rise && riseCnt_q < 8'h05 |-> tms)
		else $error("tms low during reset walk");
	a_tap_path:
	assert property (rise && riseCnt_q < 8'h21 |-> tms == TMS_EXP[riseCnt_q])
		else $error("tms off the scan path");
	a_enable_bits:
	assert property (rise && riseCnt_q inside {[8'h0A:8'h11]}
		|-> tdi == EN_OP[3'(riseCnt_q - 8'h0A)])
		else $error("enable opcode bit wrong");
	a_erase_bits:
	assert property (rise && riseCnt_q inside {[8'h17:8'h1E]}
		|-> tdi == ER_OP[3'(riseCnt_q - 8'h17)])
		else $error("erase opcode bit wrong");
	a_update_idle:
	assert property (rise && riseCnt_q == 8'h20 |-> !tms ##[1:9] eraseActive)
		else $error("erase not running in idle");
	a_dwell_len:
	assert property ($rose(done) |-> riseCnt_q >= 8'(37 + ERASE_CYC / 10))
		else $error("erase dwell too short");
	a_final_path:
	assert property ($rose(done) |-> lastTms_q == 4'hC)
		else $error("scan did not end toward shift-ir");
	a_high_phase:
	assert property ($rose(tck) |-> tck [*5] ##1 !tck)
		else $error("tck high phase not five cycles");
	a_pins_low:
	assert property ($changed({tms, tdi}) |-> !tck)
		else $error("tms or tdi moved while tck high");
	a_disch_wait:
	assert property (rise && riseCnt_q == 8'h12
		|-> ##5 (!tck throughout (1'b1 ##90 1'b1)))
		else $error("no discharge wait");
	a_enable_first:
	assert property (rise && riseCnt_q == 8'h17 |-> liveReprogram)
		else $error("erase shifted before enable armed");
endmodule
`default_nettype wire

//--- testbench/jses_sequencer_bench.sv
// self-checking bench: sequencer and device joined by the scan link
`default_nettype none
module jses_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned ERASE_N = 50;
	logic        clk;
	logic        rstn;
	logic        start;
	logic        busy;
	logic        done;
	logic        liveReprogram;
	logic        eraseActive;
	logic        tck_q;
	logic        eraseSeen;
	logic [32:0] tmsSeen;
	logic [7:0]  enSeen;
	logic [7:0]  erSeen;
	int          riseN;
	int          cycles;
	int          error_cnt;
	int          total_checks;

	jses_jtag_if link();
	jses_sequencer #(.ERASE_CYC(ERASE_N)) u_jses_sequencer
	(
		.clk   (clk),
		.rstn  (rstn),
		.start (start),
		.jtag  (link.host),
		.busy  (busy),
		.done  (done)
	);
	jses_tap_device u_jses_tap_device
	(
		.clk           (clk),
		.rstn          (rstn),
		.jtag          (link.dev),
		.liveReprogram (liveReprogram),
		.eraseActive   (eraseActive)
	);
	jses_monitor #(.ERASE_CYC(ERASE_N)) u_jses_monitor
	(
		.clk           (clk),
		.rstn          (rstn),
		.tck           (link.tck),
		.tms           (link.tms),
		.tdi           (link.tdi),
		.done          (done),
		.liveReprogram (liveReprogram),
		.eraseActive   (eraseActive)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// snoop the link: what the device saw at each tck rise
	always @(posedge clk)
	begin
		tck_q <= link.tck;
		if (link.tck && !tck_q)
		begin
			if (riseN < 33)
				tmsSeen[riseN] <= link.tms;
			if (riseN >= 10 && riseN < 18)
				enSeen[riseN - 10] <= link.tdi;
			if (riseN >= 23 && riseN < 31)
				erSeen[riseN - 23] <= link.tdi;
			riseN <= riseN + 1;
		end
		if (eraseActive === 1'b1)
			eraseSeen <= 1'b1;
		cycles <= cycles + 1;
		if (cycles > 5000)
		begin
			error_cnt++;
			report_and_stop;
		end
	end

	// holdStart keeps start high until the last steps: ignored while busy;
	// it drops before done, since a start seen in idle begins a new scan
	task automatic run_scan(input logic holdStart);
		int n;
		n = 0;
		riseN = 0;
		eraseSeen = 1'b0;
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= holdStart;
		@(negedge clk);
		check("busy", 64'(busy), 64'h1);
		while (done !== 1'b1 && n < 2000)
		begin
			@(posedge clk);
			if (riseN > 40)
				start <= 1'b0;
			@(negedge clk);
			n++;
		end
		check("scan done", 64'(done), 64'h1);
		check("busy at end", 64'(busy), 64'h0);
		check("tms path", 64'(tmsSeen), 64'h0C01E00DF);
		check("enable opcode", 64'(enSeen), 64'hE4);
		check("erase opcode", 64'(erSeen), 64'hED);
		check("dwell", 64'(riseN >= 37 + ERASE_N / 10), 64'h1);
		check("armed", 64'(liveReprogram), 64'h1);
		check("erase ran", 64'(eraseSeen), 64'h1);
		check("erase ended", 64'(eraseActive), 64'h0);
		@(posedge clk);
		start <= 1'b0;
		@(negedge clk);
		check("done pulse", 64'(done), 64'h0);
	endtask

	initial
	begin
		rstn = 1'b0;
		start = 1'b0;
		tck_q = 1'b0;
		riseN = 0;
		cycles = 0;
		error_cnt = 0;
		total_checks = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		run_scan(1'b0);
		$display("test plain scan over");
		run_scan(1'b1);
		$display("test held start over");
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (150) @(posedge clk);
		rstn <= 1'b0;
		@(negedge clk);
		check("reset busy", 64'(busy), 64'h0);
		check("reset tck", 64'(link.tck), 64'h0);
		check("reset tms", 64'(link.tms), 64'h1);
		check("reset armed", 64'(liveReprogram), 64'h0);
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		run_scan(1'b0);
		$display("test reset mid scan over");
		report_and_stop;
	end
endmodule
`default_nettype wire
